//--- rtl/dtcs_burst_timer.sv
// Burst and pause sequencer for the tone transmitter
`timescale 1ns/100ps
module dtcs_burst_timer
  import dtcs_pkg::*;
#(
  parameter int unsigned BURST_LEN = BURST_CYCLES
) (
  input wire logic sysClk,
  input wire logic arst_n,
  input wire logic clkEn,
  input wire logic start,
  input wire logic doubleLen,
  input wire logic abort,
  output logic toneOn,
  output logic pauseDone
);
  // Elaboration check: the counter must hold a doubled phase
  if (BURST_LEN < 1 || BURST_LEN * 2 >= (1 << CNT_W)) begin : g_len_chk
    $error("BURST_LEN out of range");
  end

  // One-hot sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_TONE = 3'b010,
    ST_PAUSE = 3'b100
  } dtcs_bt_state_t;

  dtcs_bt_state_t state_q;
  logic [CNT_W-1:0] cnt_q; // Cycles left in current phase
  logic [CNT_W-1:0] len_q; // Phase length latched at start

  // Length of one phase, doubled in call progress mode
  function automatic logic [CNT_W-1:0] phaseLen(input logic dbl);
    phaseLen = dbl ? CNT_W'(BURST_LEN * 2) : CNT_W'(BURST_LEN);
  endfunction

  // Tone then equal silent pause, then a one-cycle done pulse
  always_ff @(posedge sysClk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= ST_IDLE;
      cnt_q <= '0;
      len_q <= '0;
      pauseDone <= 1'b0;
    end else if (clkEn) begin
      pauseDone <= 1'b0;
      if (abort) begin
        // Leaving burst mode drops any burst in flight
        state_q <= ST_IDLE;
      end else begin
        case (state_q)
          ST_IDLE: begin
            if (start) begin
              state_q <= ST_TONE;
              len_q <= phaseLen(doubleLen);
              cnt_q <= phaseLen(doubleLen) - CNT_W'(1);
            end
          end
          ST_TONE: begin
            if (cnt_q == '0) begin
              state_q <= ST_PAUSE;
              cnt_q <= len_q - CNT_W'(1);
            end else begin
              cnt_q <= cnt_q - CNT_W'(1);
            end
          end
          ST_PAUSE: begin
            if (cnt_q == '0) begin
              state_q <= ST_IDLE;
              pauseDone <= 1'b1;
            end else begin
              cnt_q <= cnt_q - CNT_W'(1);
            end
          end
          default: state_q <= ST_IDLE;
        endcase
      end
    end
  end

  assign toneOn = (state_q == ST_TONE);
endmodule // dtcs_burst_timer

//--- rtl/dtcs_pkg.sv
// Package: register map, field positions, timing and carrier types
package dtcs_pkg;
  // Control register bit positions, primary register
  localparam int PRI_TONE_EN = 0;
  localparam int PRI_CP_MODE = 1;
  localparam int PRI_IRQ_EN = 2;
  localparam int PRI_SEL_SEC = 3;
  // Control register bit positions, secondary register
  localparam int SEC_BURST_N = 0;
  localparam int SEC_TEST = 1;
  localparam int SEC_SINGLE = 2;
  localparam int SEC_COLUMN = 3;
  // Status register bit positions
  localparam int STS_IRQ = 0;
  localparam int STS_TX_EMPTY = 1;
  localparam int STS_RX_FULL = 2;
  localparam int STS_DLY_STEER = 3;
  // Reset values
  localparam logic [3:0] PRI_RESET = 4'h0;
  localparam logic [3:0] SEC_RESET = 4'h0;
  localparam logic [3:0] STS_RESET = 4'h0;
  // Register select line values
  localparam logic SEL_DATA = 1'b0;
  localparam logic SEL_CTRL = 1'b1;
  // Burst duration, DTMF mode, in microseconds
  localparam int BURST_US = 51000;
  localparam int CLK_MHZ = 100;
  localparam int BURST_CYCLES = BURST_US * CLK_MHZ;
  localparam int CNT_W = 25;

  // Tone generator selection carried to the tone path
  typedef struct packed {
    logic enable;
    logic lowGroup;
    logic highGroup;
  } dtcs_tone_sel_t;

  // Host bus access strobes, one cycle each
  typedef struct packed {
    logic wr;
    logic rd;
    logic regSel;
    logic [3:0] data;
  } dtcs_bus_t;
endpackage

//--- rtl/dtcs_tone_ctrl_status.sv
// Tone control and status register bank of the DTMF transceiver
`timescale 1ns/100ps
// Overview of operation
// - Burst bit 0: tone burst, equal pause
// - After pause: set transmit-ready, interrupt if enabled outside call progress and test modes
// - Call progress with burst doubles both lengths
// - Burst bit 1: tone follows host enable
// - Test bit drives pin with inverted steering
// - Single/dual bit selects one or two tones
// - Single tone: row when 0, column when 1
// - Status bit0 summarises bits 1 and 2
// - Transmit-ready cleared on read or non-burst
// - Receive-full set on valid code load
// - Delayed steering follows signal absence/presence
// - Select bit routes next control write secondary
// - Interrupt pin low on tone or ready
module dtcs_tone_ctrl_status
  import dtcs_pkg::*;
#(
  parameter int unsigned BURST_LEN = BURST_CYCLES
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic clkEn,
  input wire logic busWr,
  input wire logic busRd,
  input wire logic register_select_line,
  input wire logic [3:0] busWrData,
  input wire logic txLoad,
  input wire logic rxCodeValid,
  input wire logic steerValid,
  input wire logic steerAbsent,
  input wire logic dlySteer,
  input wire logic cpToneIn,
  output logic [3:0] statusData,
  output logic [3:0] primaryCtrl,
  output dtcs_tone_sel_t toneSel,
  output logic intPinOut,
  output logic intPinOe
);
  // Bus strobes are on this clock; the analog-side levels are not
  logic [2:0] syncA_q; // First stage, read only by stage two
  logic [2:0] syncB_q; // Stage two, safe for logic
  logic cpTone;
  logic dlySteerS;
  logic steerS;

  logic [3:0] primary_q; // Primary control register
  logic [3:0] secondary_control_register_q; // Secondary control register
  logic secNext_q; // Next control write goes secondary
  logic [3:0] status_q;
  logic [3:0] status_d;
  logic [3:0] setEv; // Flags raised by hardware this cycle
  logic rdPend_q; // Clear-on-read waits one cycle
  logic [3:0] rdSnap_q; // Flags shown to the reader
  logic toneOn;
  logic pauseDone;
  logic burstMode;
  logic steerPrev_q;
  logic steerRise;

  // Two-flop synchronisers for asynchronous levels
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      syncA_q <= 3'h0;
      syncB_q <= 3'h0;
    end else if (clkEn) begin
      syncA_q <= {steerValid, dlySteer, cpToneIn};
      syncB_q <= syncA_q;
    end
  end
  assign cpTone = syncB_q[0];
  assign dlySteerS = syncB_q[1];
  assign steerS = syncB_q[2];

  // Rising edge of valid steering marks a tone held for guard time
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      steerPrev_q <= 1'b0;
    end else if (clkEn) begin
      steerPrev_q <= steerS;
    end
  end
  assign steerRise = steerS & ~steerPrev_q;

  // Control writes share one address; select bit steers the next one
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      primary_q <= PRI_RESET;
      secondary_control_register_q <= SEC_RESET;
      secNext_q <= 1'b0;
    end else if (clkEn && busWr && register_select_line == SEL_CTRL) begin
      if (secNext_q) begin
        secondary_control_register_q <= busWrData;
        secNext_q <= 1'b0;
      end else begin
        primary_q <= busWrData;
        secNext_q <= busWrData[PRI_SEL_SEC];
      end
    end
  end

  // Burst mode is active low in the secondary register
  assign burstMode = ~secondary_control_register_q[SEC_BURST_N];

  dtcs_burst_timer #(
    .BURST_LEN(BURST_LEN)
  ) u_timer (
    .sysClk(sys_clk),
    .arst_n(arst_n),
    .clkEn(clkEn),
    .start(busWr && register_select_line == SEL_DATA
           && burstMode && txLoad),
    .doubleLen(primary_q[PRI_CP_MODE]),
    .abort(~burstMode),
    .toneOn(toneOn),
    .pauseDone(pauseDone)
  );

  // Flags raised by the hardware in this cycle
  always_comb begin
    setEv = 4'h0;
    setEv[STS_TX_EMPTY] = pauseDone & burstMode;
    setEv[STS_RX_FULL] = rxCodeValid;
  end

  // Status next value: hardware sets beat the read clear
  always_comb begin
    status_d = status_q;
    if (rdPend_q) begin
      // Clear only flags the reader actually saw
      status_d[STS_TX_EMPTY] = status_q[STS_TX_EMPTY]
                               & ~rdSnap_q[STS_TX_EMPTY];
      status_d[STS_RX_FULL] = status_q[STS_RX_FULL]
                              & ~rdSnap_q[STS_RX_FULL];
    end
    if (setEv[STS_TX_EMPTY]) begin
      status_d[STS_TX_EMPTY] = 1'b1;
    end
    if (!burstMode) begin
      status_d[STS_TX_EMPTY] = 1'b0;
    end
    if (setEv[STS_RX_FULL]) begin
      status_d[STS_RX_FULL] = 1'b1;
    end
    // Summary is derived, so a partial clear cannot strand it
    status_d[STS_IRQ] = status_d[STS_TX_EMPTY]
                        | status_d[STS_RX_FULL];
    // Delayed steering tracks the receiver, reads leave it alone
    if (steerAbsent) begin
      status_d[STS_DLY_STEER] = 1'b1;
    end else if (steerRise) begin
      status_d[STS_DLY_STEER] = 1'b0;
    end
  end

  // Status register and deferred read clear
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      status_q <= STS_RESET;
      rdPend_q <= 1'b0;
      rdSnap_q <= 4'h0;
    end else if (clkEn) begin
      status_q <= status_d;
      rdPend_q <= busRd && register_select_line == SEL_CTRL;
      // A flag raised at the read edge was not seen, so it must survive
      rdSnap_q <= status_q & ~setEv;
    end
  end

  // Read data latched from flags before any clear
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      statusData <= 4'h0;
    end else if (clkEn && busRd && register_select_line == SEL_CTRL) begin
      statusData <= status_q;
    end
  end

  // Tone selection to the transmitter
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      toneSel <= '0;
      primaryCtrl <= PRI_RESET;
    end else if (clkEn) begin
      primaryCtrl <= primary_q;
      // Non-burst: host enable alone gates the tone
      toneSel.enable <= primary_q[PRI_TONE_EN]
                        & (burstMode ? toneOn : 1'b1);
      if (!secondary_control_register_q[SEC_SINGLE]) begin
        toneSel.lowGroup <= 1'b1;
        toneSel.highGroup <= 1'b1;
      end else begin
        // Row is low group, column is high group
        toneSel.lowGroup <=
          ~secondary_control_register_q[SEC_COLUMN];
        toneSel.highGroup <=
          secondary_control_register_q[SEC_COLUMN];
      end
    end
  end

  // Open-drain pin; oe high means pulling low
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      intPinOut <= 1'b0;
      intPinOe <= 1'b0;
    end else if (clkEn) begin
      intPinOut <= 1'b0;
      if (secondary_control_register_q[SEC_TEST]) begin
        // Inverted delayed steering; takes priority over call progress mode
        intPinOe <= dlySteerS;
      end else if (primary_q[PRI_IRQ_EN] && primary_q[PRI_CP_MODE]) begin
        intPinOe <= ~cpTone; // Call progress square wave
      end else if (primary_q[PRI_IRQ_EN]) begin
        intPinOe <= status_q[STS_IRQ];
      end else begin
        intPinOe <= 1'b0;
      end
    end
  end
endmodule // dtcs_tone_ctrl_status

//--- sim/dtcs_host_model.sv
// Host model: control and status cycles on the parallel bus
`timescale 1ns/100ps
module dtcs_host_model
  import dtcs_pkg::*;
(
  input wire logic clk,
  input wire logic [3:0] stsIn,
  output dtcs_bus_t hostBus
);
  initial hostBus = '0;
  // One write; released lines show the inverse, not stale data
  task automatic wrReg(input logic rs, input logic [3:0] d);
    @(posedge clk);
    hostBus <= '{wr: 1'b1, rd: 1'b0, regSel: rs, data: d};
    @(posedge clk);
    hostBus <= '{wr: 1'b0, rd: 1'b0, regSel: ~rs, data: ~d};
  endtask
  // One status read; value stands after the taking edge
  task automatic rdSts(output logic [3:0] v);
    @(posedge clk);
    hostBus.rd <= 1'b1;
    hostBus.regSel <= SEL_CTRL;
    @(posedge clk);
    hostBus.rd <= 1'b0;
    @(negedge clk);
    v = stsIn;
  endtask
endmodule // dtcs_host_model

//--- sim/dtcs_tone_ctrl_status_checker.sv
// Checker: port assertions for the tone control and status bank
`timescale 1ns/100ps
module dtcs_tone_ctrl_status_checker
  import dtcs_pkg::*;
#(
  parameter int unsigned BURST_LEN = 20
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic clkEn,
  input wire logic busWr,
  input wire logic busRd,
  input wire logic register_select_line,
  input wire logic [3:0] busWrData,
  input wire logic rxCodeValid,
  input wire logic dlySteer,
  input wire logic [3:0] statusData,
  input wire logic [3:0] primaryCtrl,
  input wire dtcs_tone_sel_t toneSel,
  input wire logic intPinOut,
  input wire logic intPinOe
);
  logic selPendQ; // Next control write goes to secondary
  logic [3:0] secQ; // Shadow of the secondary register
  int unsigned cntQ; // Cycles the tone has been on
  logic rdS; // Status read taken this edge
  assign rdS = clkEn && busRd && register_select_line;
  // Shadow the secondary register from bus writes
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      selPendQ <= 1'b0;
      secQ <= SEC_RESET;
    end else if (clkEn && busWr && register_select_line) begin
      selPendQ <= !selPendQ && busWrData[PRI_SEL_SEC];
      if (selPendQ) begin
        secQ <= busWrData;
      end
    end
  end
  // Tone-on length; frozen with the clock enable
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cntQ <= 0;
    end else if (clkEn) begin
      cntQ <= toneSel.enable ? cntQ + 1 : 0;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  a_pin_never_high: assert property (intPinOut == 1'b0)
    else $error("interrupt pin driven high");
  a_status_holds: assert property (!rdS |=> $stable(statusData))
    else $error("status moved without a read");
  a_irq_summary: assert property (statusData[STS_IRQ] ==
    (statusData[STS_TX_EMPTY] | statusData[STS_RX_FULL]))
    else $error("summary flag wrong");
  a_rx_sets: assert property ((clkEn && rxCodeValid)
    ##1 !busRd ##1 rdS
    |=> statusData[STS_RX_FULL]) else $error("receive flag missing");
  a_rx_read_clears: assert property ((rdS && !rxCodeValid) ##1
    !rxCodeValid ##1 (rdS && !rxCodeValid)
    |=> !statusData[STS_RX_FULL]) else $error("receive flag kept");
  a_burst_length: assert property ($fell(toneSel.enable) &&
    !secQ[SEC_BURST_N] |-> cntQ == (primaryCtrl[PRI_CP_MODE] ?
    2 * BURST_LEN : BURST_LEN)) else $error("burst length wrong");
  a_tone_groups: assert property (toneSel.enable |->
    toneSel.lowGroup == !($past(secQ[SEC_SINGLE]) && $past(secQ[3])) &&
    toneSel.highGroup == !($past(secQ[SEC_SINGLE]) && !$past(secQ[3])))
    else $error("tone groups wrong");
  a_test_pin: assert property ((secQ[SEC_TEST]
    && $stable(dlySteer)) [*5] |-> intPinOe == dlySteer)
    else $error("test pin wrong");
  a_nonburst_ready: assert property (secQ[SEC_BURST_N] [*3] ##1 rdS
    |=> !statusData[STS_TX_EMPTY]) else $error("ready set in free run");
endmodule // dtcs_tone_ctrl_status_checker

//--- sim/test_dtcs_tone_ctrl_status.sv
// Testbench for the tone control and status register bank
`timescale 1ns/100ps
module test_dtcs_tone_ctrl_status;
  import dtcs_pkg::*;
  localparam int unsigned L = 20; // Short burst for simulation
  logic sysClk, arstN, rxCodeValid, steerValid, steerAbsent, dlySteer;
  logic [3:0] sts, statusData, primaryCtrl;
  logic intPinOut, intPinOe;
  dtcs_tone_sel_t toneSel;
  dtcs_bus_t hostBus;
  int nErrors, nTests, cycles;
  always #5 sysClk = ~sysClk;
  dtcs_host_model i_host (.clk(sysClk), .stsIn(statusData),
    .hostBus(hostBus));
  dtcs_tone_ctrl_status #(.BURST_LEN(L)) i_dut (.sys_clk(sysClk),
    .arst_n(arstN), .clkEn(1'b1), .busWr(hostBus.wr),
    .busRd(hostBus.rd), .register_select_line(hostBus.regSel),
    .busWrData(hostBus.data), .txLoad(1'b1), .rxCodeValid(rxCodeValid),
    .steerValid(steerValid), .steerAbsent(steerAbsent),
    .dlySteer(dlySteer), .cpToneIn(1'b0), .statusData(statusData),
    .primaryCtrl(primaryCtrl), .toneSel(toneSel), .intPinOut(intPinOut),
    .intPinOe(intPinOe));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    nTests++;
    if (got !== exp) begin
      nErrors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic conclude;
    $display("checks=%0d mismatches=%0d", nTests, nErrors);
    if (nErrors == 0 && nTests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic ticks(input int n);
    repeat (n) @(negedge sysClk);
  endtask
  // Hang guard; whole run is well under this
  always @(posedge sysClk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      nErrors++;
      conclude();
    end
  end
  // Timed burst; call progress doubles burst and pause
  task automatic tBurst(input logic cp);
    int n;
    int k;
    k = cp ? 2 : 1;
    i_host.wrReg(1'b1, {2'b11, cp, 1'b1});
    i_host.wrReg(1'b1, 4'h0);
    i_host.wrReg(1'b0, 4'h7);
    n = 0;
    while (!toneSel.enable && n < 10) begin
      ticks(1);
      n++;
    end
    n = 0;
    while (toneSel.enable && n < 200) begin
      ticks(1);
      n++;
    end
    chk(8'(n), 8'(L * k));
    ticks(L * k + 3);
    if (!cp) chk(intPinOe, 1'b1);
    i_host.rdSts(sts);
    chk(sts, 4'h3);
    i_host.rdSts(sts);
    chk(sts, 4'h0);
  endtask
  // Free-running tones in every group selection
  task automatic tFree;
    i_host.wrReg(1'b1, 4'h8);
    i_host.wrReg(1'b1, 4'h1);
    i_host.wrReg(1'b1, 4'h1);
    ticks(3);
    chk(primaryCtrl, 4'h1);
    chk(toneSel, 3'b111);
    for (int i = 0; i < 2; i++) begin
      i_host.wrReg(1'b1, 4'h9);
      i_host.wrReg(1'b1, i ? 4'hd : 4'h5);
      ticks(3);
      chk(toneSel, i ? 3'b101 : 3'b110);
    end
    ticks(3 * L);
    chk(toneSel.enable, 1'b1);
    i_host.wrReg(1'b1, 4'h0);
    ticks(3);
    chk(toneSel, 3'b001);
    i_host.rdSts(sts);
    chk(sts, 4'h0);
  endtask
  // Receive flag, then delayed steering flag
  task automatic tRxSteer;
    @(posedge sysClk) rxCodeValid <= 1'b1;
    @(posedge sysClk) rxCodeValid <= 1'b0;
    i_host.rdSts(sts);
    chk(sts, 4'h5);
    i_host.rdSts(sts);
    chk(sts, 4'h0);
    @(posedge sysClk) steerAbsent <= 1'b1;
    @(posedge sysClk) steerAbsent <= 1'b0;
    for (int i = 0; i < 2; i++) begin
      i_host.rdSts(sts);
      chk(sts, 4'h8);
    end
    @(posedge sysClk) steerValid <= 1'b1;
    ticks(5);
    i_host.rdSts(sts);
    chk(sts, 4'h0);
  endtask
  // Test mode: pin shows inverted delayed steering
  task automatic tTest;
    i_host.wrReg(1'b1, 4'h8);
    i_host.wrReg(1'b1, 4'h3);
    for (int i = 1; i >= 0; i--) begin
      @(posedge sysClk) dlySteer <= i[0];
      ticks(6);
      chk(intPinOe, i[0]);
    end
  endtask
  initial begin
    sysClk = 0;
    arstN = 0;
    {rxCodeValid, steerValid, steerAbsent, dlySteer} = '0;
    {cycles, nErrors, nTests} = '0;
    repeat (12) @(posedge sysClk);
    arstN <= 1'b1;
    i_host.rdSts(sts);
    chk(sts, STS_RESET);
    tBurst(1'b0);
    tBurst(1'b1);
    tFree;
    tRxSteer;
    tTest;
    conclude;
  end
endmodule // test_dtcs_tone_ctrl_status
bind dtcs_tone_ctrl_status dtcs_tone_ctrl_status_checker #(
  .BURST_LEN(BURST_LEN)) i_chk (.sys_clk(sys_clk), .arst_n(arst_n),
  .clkEn(clkEn), .busWr(busWr), .busRd(busRd),
  .register_select_line(register_select_line), .busWrData(busWrData),
  .rxCodeValid(rxCodeValid), .dlySteer(dlySteer),
  .statusData(statusData), .primaryCtrl(primaryCtrl), .toneSel(toneSel),
  .intPinOut(intPinOut), .intPinOe(intPinOe));
